// [rtl/bdm_ctrl.sv]
// Chosen here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
module bdm_ctrl
	import bdm_pkg::*;
#(
	parameter logic [31:0] IDLE_CYC  = bdm_pkg::BDM_IDLE_CYC,
	parameter logic [31:0] FACT_CYC  = bdm_pkg::BDM_FACT_CYC,
	parameter logic [31:0] HOLD_CYC  = bdm_pkg::BDM_HOLD_CYC,
	parameter logic [31:0] CUE_CYC   = bdm_pkg::BDM_CUE_CYC,
	parameter logic [31:0] DEB_CYC   = bdm_pkg::BDM_DEB_CYC,
	parameter logic [31:0] BLINK_CYC = bdm_pkg::BDM_BLINK_CYC
) (
	input  wire logic                        hclk,        // 40 MHz clock
	input  wire logic                        hresetn,     // async reset, low
	input  wire logic                        hsel,        // slave select
	input  wire logic [31:0]                 haddr,       // byte address
	input  wire logic [1:0]                  htrans,      // transfer type
	input  wire logic                        hwrite,      // write when high
	input  wire logic [2:0]                  hsize,       // word only
	input  wire logic [31:0]                 hwdata,      // write data
	input  wire logic                        hready,      // bus ready in
	output logic [31:0]                      hrdata,      // read data
	output logic                             hreadyout,   // slave ready
	output logic                             hresp,       // always okay
	input  wire logic                        button_in,   // raw pin, high=pressed
	input  wire logic [bdm_pkg::BDM_STATE_W-1:0] port_state, // port/supply state
	output logic                             led_green,   // mode lamp green
	output logic                             led_red,     // mode lamp red
	output logic [1:0]                       display_mode,// active mode
	output logic                             factory_rst, // restore pulse
	output logic                             rm_enable,   // manager role on
	output logic                             mre_enable,  // media redundancy on
	output logic                             fault,       // state off mask
	output logic                             irq          // interrupt level
);

	import bdm_pkg::*;

	logic                   btn_db;
	logic                   blink;
	logic                   btn_prev_ff;
	logic [31:0]            hold_ff, nxt_hold;
	logic [31:0]            idle_ff, nxt_idle;
	bdm_mode_e              mode_ff, nxt_mode;
	logic                   rel, short_press, timeout, cue;
	logic                   fact_hit, mask_hit, rm_hit;
	logic                   rm_ff, nxt_rm, mre_ff, nxt_mre;
	logic [31:0]            mask_ff, nxt_mask;
	logic                   fault_ff, fault_cond;
	logic                   fact_ff, green_ff, red_ff, nxt_green, nxt_red;
	logic [BDM_IRQ_W-1:0]   ev, ist_ff, nxt_ist, ien_ff, nxt_ien;
	logic                   irq_ff;
	logic [31:0]            st_ext;
	logic                   wr_pend_ff, rd_pend_ff, nxt_wr_pend, nxt_rd_pend;
	logic [7:0]             addr_ff, nxt_addr;
	logic [31:0]            rdata_ff, nxt_rdata;
	logic                   ready_ff, nxt_ready;
	logic                   sw_ctrl_wr, sw_clr_wr, sw_en_wr;

	// ---------------------------------------------------------------
	// button conditioning and flash source
	// ---------------------------------------------------------------
	bdm_debounce #(
		.DEB_CYC  (DEB_CYC)
	) u_debounce (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.pin_in   (button_in),
		.level_ff (btn_db)
	);

	bdm_blink #(
		.HALF_CYC (BLINK_CYC)
	) u_blink (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.phase_ff (blink)
	);

	// ---------------------------------------------------------------
	// press classification
	// ---------------------------------------------------------------
	// mode cannot change while held, so each hit fires once per press
	assign rel         = btn_prev_ff && !btn_db;
	assign short_press = rel && (hold_ff < CUE_CYC);
	assign fact_hit    = btn_db && mode_ff == BDM_MODE_A
		&& hold_ff == FACT_CYC - 32'd1;
	assign mask_hit    = btn_db && hold_ff == HOLD_CYC - 32'd1
		&& (mode_ff == BDM_MODE_A || mode_ff == BDM_MODE_D);
	assign rm_hit      = btn_db && mode_ff == BDM_MODE_B
		&& hold_ff == HOLD_CYC - 32'd1;
	assign timeout     = !btn_db && idle_ff == IDLE_CYC - 32'd1
		&& mode_ff != BDM_MODE_A;
	assign cue         = btn_db && hold_ff >= CUE_CYC
		&& mode_ff != BDM_MODE_C;
	assign fault_cond  = 32'(port_state) != mask_ff;

	// ---------------------------------------------------------------
	// hold and idle timers, display mode
	// ---------------------------------------------------------------
	// hold count drops to zero on release, so a new press starts fresh
	always_comb begin
		nxt_hold = 32'd0;
		if (btn_db) begin
			nxt_hold = (hold_ff == 32'hffff_ffff) ? hold_ff : hold_ff + 32'd1;
		end
		nxt_idle = 32'd0;
		if (!btn_db) begin
			nxt_idle = (idle_ff == IDLE_CYC - 32'd1) ? idle_ff : idle_ff + 32'd1;
		end
		nxt_mode = mode_ff;
		if (short_press) begin
			nxt_mode = bdm_mode_e'(mode_ff + 2'd1);
		end else if (timeout) begin
			nxt_mode = BDM_MODE_A;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			btn_prev_ff <= 1'b0;
			hold_ff     <= 32'd0;
			idle_ff     <= 32'd0;
			mode_ff     <= BDM_MODE_A;
		end else begin
			btn_prev_ff <= btn_db;
			hold_ff     <= nxt_hold;
			idle_ff     <= nxt_idle;
			mode_ff     <= nxt_mode;
		end
	end

	// ---------------------------------------------------------------
	// configuration: manager role, media redundancy, fault mask
	// ---------------------------------------------------------------
	// a factory restore wins over any other update in the same cycle
	always_comb begin
		nxt_rm   = rm_ff;
		nxt_mre  = mre_ff;
		nxt_mask = mask_ff;
		if (sw_ctrl_wr) begin
			nxt_rm  = hwdata[BDM_CTRL_RM];
			nxt_mre = hwdata[BDM_CTRL_MRE];
		end
		if (rm_hit) begin
			nxt_rm = ~rm_ff;
			if (!rm_ff) begin
				nxt_mre = 1'b1;
			end
			// clearing the role keeps nxt_mre as it stands
		end
		if (mask_hit) begin
			nxt_mask = 32'(port_state);
		end
		if (fact_hit) begin
			nxt_rm   = BDM_RM_RST;
			nxt_mre  = BDM_MRE_RST;
			nxt_mask = BDM_MASK_RST;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rm_ff    <= BDM_RM_RST;
			mre_ff   <= BDM_MRE_RST;
			mask_ff  <= BDM_MASK_RST;
			fault_ff <= 1'b0;
			fact_ff  <= 1'b0;
		end else begin
			rm_ff    <= nxt_rm;
			mre_ff   <= nxt_mre;
			mask_ff  <= nxt_mask;
			fault_ff <= fault_cond;
			fact_ff  <= fact_hit;
		end
	end

	// ---------------------------------------------------------------
	// mode indicator lamp
	// ---------------------------------------------------------------
	// orange is both dies lit; the hold cue flashes green in B and orange in A and D
	always_comb begin
		case (mode_ff)
			BDM_MODE_A: begin
				nxt_green = 1'b0;
				nxt_red   = 1'b0;
			end
			BDM_MODE_B: begin
				nxt_green = 1'b1;
				nxt_red   = 1'b0;
			end
			BDM_MODE_C: begin
				nxt_green = 1'b1;
				nxt_red   = 1'b1;
			end
			BDM_MODE_D: begin
				nxt_green = blink;
				nxt_red   = blink;
			end
			default: begin
				nxt_green = 1'b0;
				nxt_red   = 1'b0;
			end
		endcase
		if (cue) begin
			nxt_green = blink;
			nxt_red   = blink && mode_ff != BDM_MODE_B;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			green_ff <= 1'b0;
			red_ff   <= 1'b0;
		end else begin
			green_ff <= nxt_green;
			red_ff   <= nxt_red;
		end
	end

	// ---------------------------------------------------------------
	// interrupt status, clear and enable
	// ---------------------------------------------------------------
	always_comb begin
		ev                = '0;
		ev[BDM_EV_PRESS]  = short_press;
		ev[BDM_EV_IDLE]   = timeout;
		ev[BDM_EV_FACT]   = fact_hit;
		ev[BDM_EV_MASK]   = mask_hit;
		ev[BDM_EV_RM]     = rm_hit;
		ev[BDM_EV_FAULT]  = fault_cond && !fault_ff;
		// a new event wins over a clear in the same cycle
		nxt_ist = ist_ff;
		if (sw_clr_wr) begin
			nxt_ist = ist_ff & ~hwdata[BDM_IRQ_W-1:0];
		end
		nxt_ist = nxt_ist | ev;
		nxt_ien = ien_ff;
		if (sw_en_wr) begin
			nxt_ien = hwdata[BDM_IRQ_W-1:0];
		end
		if (fact_hit) begin
			nxt_ien = BDM_IRQ_EN_RST;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ist_ff <= '0;
			ien_ff <= BDM_IRQ_EN_RST;
			irq_ff <= 1'b0;
		end else begin
			ist_ff <= nxt_ist;
			ien_ff <= nxt_ien;
			irq_ff <= |(ist_ff & ien_ff);
		end
	end

	// ---------------------------------------------------------------
	// bus slave: writes in zero wait, reads with one wait state
	// ---------------------------------------------------------------
	// the wait lets a read see a write that closed just before it
	assign sw_ctrl_wr = wr_pend_ff && addr_ff == BDM_REG_CTRL;
	assign sw_clr_wr  = wr_pend_ff && addr_ff == BDM_REG_IRQ_CLR;
	assign sw_en_wr   = wr_pend_ff && addr_ff == BDM_REG_IRQ_EN;

	always_comb begin
		st_ext                 = 32'd0;
		st_ext[BDM_ST_MODE_LO +: 2] = mode_ff;
		st_ext[BDM_ST_BTN]     = btn_db;
		st_ext[BDM_ST_CUE]     = cue;
		st_ext[BDM_ST_FAULT]   = fault_ff;
		st_ext[BDM_ST_RM]      = rm_ff;
		st_ext[BDM_ST_MRE]     = mre_ff;
	end

	always_comb begin
		nxt_wr_pend = 1'b0;
		nxt_rd_pend = 1'b0;
		nxt_addr    = addr_ff;
		nxt_ready   = 1'b1;
		nxt_rdata   = rdata_ff;
		if (hsel && htrans[1] && hready) begin
			nxt_addr    = haddr[7:0];
			nxt_wr_pend = hwrite;
			nxt_rd_pend = !hwrite;
			nxt_ready   = hwrite;
		end
		if (rd_pend_ff) begin
			case (addr_ff)
				BDM_REG_CTRL:   nxt_rdata = {30'd0, mre_ff, rm_ff};
				BDM_REG_STATUS: nxt_rdata = st_ext;
				BDM_REG_MASK:   nxt_rdata = mask_ff;
				BDM_REG_DIFF:   nxt_rdata = mask_ff ^ 32'(port_state);
				BDM_REG_IRQ_ST: nxt_rdata = 32'(ist_ff);
				BDM_REG_IRQ_EN: nxt_rdata = 32'(ien_ff);
				default:        nxt_rdata = 32'd0;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			rd_pend_ff <= 1'b0;
			addr_ff    <= 8'h00;
			ready_ff   <= 1'b1;
			rdata_ff   <= 32'd0;
		end else begin
			wr_pend_ff <= nxt_wr_pend;
			rd_pend_ff <= nxt_rd_pend;
			addr_ff    <= nxt_addr;
			ready_ff   <= nxt_ready;
			rdata_ff   <= nxt_rdata;
		end
	end

	// ---------------------------------------------------------------
	// outputs, all flops except hresp, which is tied to zero
	// ---------------------------------------------------------------
	assign hrdata       = rdata_ff;
	assign hreadyout    = ready_ff;
	assign hresp        = 1'b0;
	assign led_green    = green_ff;
	assign led_red      = red_ff;
	assign display_mode = mode_ff;
	assign factory_rst  = fact_ff;
	assign rm_enable    = rm_ff;
	assign mre_enable   = mre_ff;
	assign fault        = fault_ff;
	assign irq          = irq_ff;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	chk_short_advance: assert property (@(posedge hclk) disable iff (!hresetn)
		rel && hold_ff < CUE_CYC |=> mode_ff == 2'($past(mode_ff) + 2'd1))
		else $error("short press did not advance mode");

	chk_hold_no_adv: assert property (@(posedge hclk) disable iff (!hresetn)
		rel && hold_ff >= CUE_CYC |=> $stable(mode_ff))
		else $error("timed hold changed the mode");

	chk_idle_return: assert property (@(posedge hclk) disable iff (!hresetn)
		!btn_db && idle_ff == IDLE_CYC - 32'd1 |=> mode_ff == BDM_MODE_A)
		else $error("idle timeout did not return to mode a");

	chk_lamp_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
		mode_ff == BDM_MODE_A && !cue |=> !green_ff && !red_ff)
		else $error("lamp lit in mode a");

	chk_factory_fire: assert property (@(posedge hclk) disable iff (!hresetn)
		factory_rst |-> $past(btn_db) && $past(mode_ff) == BDM_MODE_A
		&& $past(hold_ff) == FACT_CYC - 32'd1)
		else $error("factory restore without full hold in mode a");

	chk_factory_dflt: assert property (@(posedge hclk) disable iff (!hresetn)
		fact_ff |-> !rm_ff && !mre_ff && mask_ff == BDM_MASK_RST)
		else $error("factory restore left user settings");

	chk_mask_capture: assert property (@(posedge hclk) disable iff (!hresetn)
		mask_hit && !fact_hit |=> mask_ff == 32'($past(port_state)))
		else $error("fault mask not captured");

	chk_mask_keep: assert property (@(posedge hclk) disable iff (!hresetn)
		!mask_hit && !fact_hit |=> $stable(mask_ff))
		else $error("fault mask changed without a full hold");

	chk_cue_flash: assert property (@(posedge hclk) disable iff (!hresetn)
		cue |=> green_ff == $past(blink))
		else $error("hold cue not flashing");

	chk_fault_flag: assert property (@(posedge hclk) disable iff (!hresetn)
		1'b1 |=> fault_ff == ($past(32'(port_state)) != $past(mask_ff)))
		else $error("fault flag does not follow the mask");

	chk_rm_toggle: assert property (@(posedge hclk) disable iff (!hresetn)
		rm_hit && !sw_ctrl_wr |=> rm_ff != $past(rm_ff) && mre_ff)
		else $error("manager toggle wrong");

	chk_rm_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		!rm_hit && !sw_ctrl_wr && !fact_hit |=> $stable(rm_ff))
		else $error("manager role changed without a full hold");

	chk_rm_off_mre: assert property (@(posedge hclk) disable iff (!hresetn)
		rm_hit && rm_ff && mre_ff && !sw_ctrl_wr |=> mre_ff)
		else $error("media redundancy dropped with manager");

	chk_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
		hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");

endmodule : bdm_ctrl

// [rtl/bdm_pkg.sv]
// Functional notes
// - each short press advances the display mode to the next one
// - no press for over one minute returns the display mode to A
// - indicator dark in A, steady green in B, flashing yellow/orange in D
// - in mode A a 12 second hold starts the factory default restore
// - release before 12 seconds in mode A cancels the factory restore
// - factory restore overwrites every user setting with its default
// - in mode A or D a 5 second hold captures states as fault mask
// - during a 5 second hold action the indicator flashes after 3 seconds
// - release before 5 seconds in A or D keeps the old fault mask
// - any state differing from the stored fault mask is flagged a fault
// - in mode B a 5 second hold toggles the redundancy manager role
// - release before 5 seconds in mode B leaves the manager role unchanged
// - enabling the manager with media redundancy off also enables it
// - disabling the manager leaves media redundancy enabled
// - from A one, two, three presses give B, C, D; C is steady orange
package bdm_pkg;

	// ---------------------------------------------------------------
	// display modes
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		BDM_MODE_A,
		BDM_MODE_B,
		BDM_MODE_C,
		BDM_MODE_D
	} bdm_mode_e;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam longint unsigned BDM_CLK_HZ    = 40_000_000;
	localparam longint unsigned BDM_IDLE_MS   = 60_000;
	localparam longint unsigned BDM_FACT_MS   = 12_000;
	localparam longint unsigned BDM_HOLD_MS   = 5_000;
	localparam longint unsigned BDM_CUE_MS    = 3_000;
	localparam longint unsigned BDM_DEB_MS    = 20;
	localparam longint unsigned BDM_BLINK_MS  = 250;
	localparam logic [31:0]     BDM_IDLE_CYC  = 32'(BDM_IDLE_MS * BDM_CLK_HZ / 1000);
	localparam logic [31:0]     BDM_FACT_CYC  = 32'(BDM_FACT_MS * BDM_CLK_HZ / 1000);
	localparam logic [31:0]     BDM_HOLD_CYC  = 32'(BDM_HOLD_MS * BDM_CLK_HZ / 1000);
	localparam logic [31:0]     BDM_CUE_CYC   = 32'(BDM_CUE_MS * BDM_CLK_HZ / 1000);
	localparam logic [31:0]     BDM_DEB_CYC   = 32'(BDM_DEB_MS * BDM_CLK_HZ / 1000);
	localparam logic [31:0]     BDM_BLINK_CYC = 32'(BDM_BLINK_MS * BDM_CLK_HZ / 1000);

	// ---------------------------------------------------------------
	// register map, byte offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] BDM_REG_CTRL    = 8'h00;
	localparam logic [7:0] BDM_REG_STATUS  = 8'h04;
	localparam logic [7:0] BDM_REG_MASK    = 8'h08;
	localparam logic [7:0] BDM_REG_DIFF    = 8'h0c;
	localparam logic [7:0] BDM_REG_IRQ_ST  = 8'h10;
	localparam logic [7:0] BDM_REG_IRQ_CLR = 8'h14;
	localparam logic [7:0] BDM_REG_IRQ_EN  = 8'h18;

	// control fields and reset values
	localparam int         BDM_CTRL_RM     = 0;
	localparam int         BDM_CTRL_MRE    = 1;
	localparam logic       BDM_RM_RST      = 1'b0;
	localparam logic       BDM_MRE_RST     = 1'b0;

	// status fields
	localparam int         BDM_ST_MODE_LO  = 0;
	localparam int         BDM_ST_BTN      = 2;
	localparam int         BDM_ST_CUE      = 3;
	localparam int         BDM_ST_FAULT    = 4;
	localparam int         BDM_ST_RM       = 5;
	localparam int         BDM_ST_MRE      = 6;

	// interrupt events
	localparam int         BDM_IRQ_W       = 6;
	localparam int         BDM_EV_PRESS    = 0;
	localparam int         BDM_EV_IDLE     = 1;
	localparam int         BDM_EV_FACT     = 2;
	localparam int         BDM_EV_MASK     = 3;
	localparam int         BDM_EV_RM       = 4;
	localparam int         BDM_EV_FAULT    = 5;
	localparam logic [BDM_IRQ_W-1:0] BDM_IRQ_EN_RST = '0;

	// fault mask default and monitored width
	localparam int         BDM_STATE_W     = 26;
	localparam logic [31:0] BDM_MASK_RST   = 32'h0000_0000;

endpackage : bdm_pkg

// [rtl/bdm_debounce.sv]
`timescale 1ns/1ps
module bdm_debounce
	import bdm_pkg::*;
#(
	parameter logic [31:0] DEB_CYC = bdm_pkg::BDM_DEB_CYC
) (
	input  wire logic hclk,     // system clock
	input  wire logic hresetn,  // async reset, low
	input  wire logic pin_in,   // raw button level, high pressed
	output logic      level_ff  // debounced level
);

	logic        s1_ff, s2_ff, s3_ff;
	logic [31:0] cnt_ff, nxt_cnt;
	logic        nxt_level;

	// ---------------------------------------------------------------
	// stability timer
	// ---------------------------------------------------------------
	// s1 only feeds s2 so metastability never reaches the compare
	always_comb begin
		nxt_cnt   = 32'd0;
		nxt_level = level_ff;
		if (s2_ff == s3_ff && s3_ff != level_ff) begin
			if (cnt_ff == DEB_CYC - 32'd1) begin
				nxt_level = s3_ff;
			end else begin
				nxt_cnt = cnt_ff + 32'd1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_ff    <= 1'b0;
			s2_ff    <= 1'b0;
			s3_ff    <= 1'b0;
			cnt_ff   <= 32'd0;
			level_ff <= 1'b0;
		end else begin
			s1_ff    <= pin_in;
			s2_ff    <= s1_ff;
			s3_ff    <= s2_ff;
			cnt_ff   <= nxt_cnt;
			level_ff <= nxt_level;
		end
	end

	chk_deb_change: assert property (@(posedge hclk) disable iff (!hresetn)
		level_ff != $past(level_ff) |-> $past(s3_ff) == level_ff)
		else $error("debounced level changed without stable input");

endmodule : bdm_debounce

// [rtl/bdm_blink.sv]
`timescale 1ns/1ps
module bdm_blink
	import bdm_pkg::*;
#(
	parameter logic [31:0] HALF_CYC = bdm_pkg::BDM_BLINK_CYC
) (
	input  wire logic hclk,     // system clock
	input  wire logic hresetn,  // async reset, low
	output logic      phase_ff  // square wave for flashing lamps
);

	logic [31:0] cnt_ff, nxt_cnt;
	logic        nxt_phase;

	// ---------------------------------------------------------------
	// free running half period divider
	// ---------------------------------------------------------------
	always_comb begin
		nxt_cnt   = cnt_ff + 32'd1;
		nxt_phase = phase_ff;
		if (cnt_ff == HALF_CYC - 32'd1) begin
			nxt_cnt   = 32'd0;
			nxt_phase = ~phase_ff;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_ff   <= 32'd0;
			phase_ff <= 1'b0;
		end else begin
			cnt_ff   <= nxt_cnt;
			phase_ff <= nxt_phase;
		end
	end

endmodule : bdm_blink

// [test/bdm_button.sv]
`timescale 1ns/1ps
module bdm_button (
	output logic pin  // button level, high while pressed
);
	// contacts chatter on both edges; a released pin sits at its pull-down
	task automatic bounce(input logic lvl);
		repeat (3) begin
			pin = lvl;
			#7;
			pin = ~lvl;
			#5;
		end
		pin = lvl;
	endtask : bounce

	// a person holds the button for cyc clock periods, then lets go
	task automatic push(input int cyc);
		bounce(1'b1);
		#(cyc * 25);
		bounce(1'b0);
	endtask : push

	initial pin = 1'b0;
endmodule : bdm_button

// [test/testbench.sv]
`timescale 1ns/1ps
module testbench;
	import bdm_pkg::*;
	logic                   hclk, hresetn, hsel, hwrite, rd, hreadyout, hresp;
	logic [31:0]            haddr, hwdata, hrdata, p;
	logic [1:0]             htrans, display_mode, led_q;
	logic [2:0]             hsize;
	logic [BDM_STATE_W-1:0] port_state;
	logic                   button_in, led_green, led_red, factory_rst;
	logic                   rm_enable, mre_enable, fault, irq;
	int                     bad_count, checks, tog, fr_cnt;
	logic [31:0]            exp_q[$];

	bdm_ctrl #(.IDLE_CYC(32'd300), .FACT_CYC(32'd120), .HOLD_CYC(32'd50),
		.CUE_CYC(32'd30), .DEB_CYC(32'd4), .BLINK_CYC(32'd4)) DUT (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .button_in(button_in), .port_state(port_state),
		.led_green(led_green), .led_red(led_red),
		.display_mode(display_mode), .factory_rst(factory_rst),
		.rm_enable(rm_enable), .mre_enable(mre_enable), .fault(fault),
		.irq(irq));
	bdm_button btn (.pin(button_in));

	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end

	// ---------------------------------------------------------------
	// checking and bus tasks
	// ---------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: saw %h, expected %h", $time, got, exp);
		end
	endtask : chk

	task end_of_test;
		$display("checks %0d, mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test

	// single word transfer; for a read, d is the expected data
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'($urandom()), a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= w ? d : $urandom();
		rd <= !w;
		if (!w) exp_q.push_back(d);
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd <= 1'b0;
	endtask : ahb

	// margin covers debounce of the release before the mode moves
	task press(input int n);
		btn.push(n);
		repeat (16) @(posedge hclk);
	endtask : press

	task lamp(input logic [1:0] m, input logic [1:0] leds, input logic bl);
		chk(32'(display_mode), 32'(m));
		tog = 0;
		repeat (20) @(posedge hclk);
		chk(32'(tog != 0), 32'(bl));
		if (!bl) chk(32'({led_green, led_red}), 32'(leds));
	endtask : lamp

	// read results, lamp toggles and restore pulses seen at the pins
	always @(posedge hclk) begin
		led_q <= {led_green, led_red};
		if ({led_green, led_red} != led_q) tog++;
		if (factory_rst === 1'b1) fr_cnt++;
		if (rd && hreadyout === 1'b1) begin
			chk(hrdata, exp_q.pop_front());
			chk(32'(hresp), 32'h0);
		end
	end

	// cut a hang short well beyond the roughly 1500 cycles needed
	initial begin
		repeat (20000) @(posedge hclk);
		bad_count++;
		end_of_test;
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		{hresetn, hsel, hwrite, rd, haddr, hwdata, htrans} = '0;
		hsize = 3'b010;
		port_state = '0;
		{bad_count, checks, tog, fr_cnt} = '0;
		void'($urandom(32'hbfb45a46));
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(0, BDM_REG_CTRL, 32'h0);
		ahb(0, 8'h40, 32'h0);
		ahb(1, BDM_REG_IRQ_EN, 32'h3f);
		ahb(0, BDM_REG_IRQ_EN, 32'h3f);
		lamp(2'd0, 2'b00, 1'b0);
		press(8 + $urandom_range(7));
		lamp(2'd1, 2'b10, 1'b0);
		ahb(0, BDM_REG_IRQ_ST, 32'h1);
		chk(32'(irq), 32'h1);
		ahb(1, BDM_REG_IRQ_CLR, 32'h1);
		ahb(0, BDM_REG_IRQ_ST, 32'h0);
		chk(32'(irq), 32'h0);
		press(8 + $urandom_range(7));
		lamp(2'd2, 2'b11, 1'b0);
		press(8 + $urandom_range(7));
		lamp(2'd3, 2'b11, 1'b1);
		ahb(1, BDM_REG_IRQ_EN, 32'h0);
		repeat (2) @(posedge hclk);
		chk(32'(irq), 32'h0);
		press(10);
		lamp(2'd0, 2'b00, 1'b0);
		press(10);
		tog = 0;
		press(40);
		chk(32'(tog != 0), 32'h1);
		chk(32'({display_mode, rm_enable}), 32'h2);
		press(75);
		ahb(0, BDM_REG_STATUS, 32'h61);
		press(75);
		chk(32'({rm_enable, mre_enable}), 32'h1);
		repeat (330) @(posedge hclk);
		chk(32'(display_mode), 32'h0);
		ahb(0, BDM_REG_IRQ_ST, 32'h13);
		p = 32'($urandom_range(32'h3ff_ffff, 1));
		port_state <= p[BDM_STATE_W-1:0];
		press(40);
		ahb(0, BDM_REG_MASK, 32'h0);
		chk(32'(fault), 32'h1);
		repeat (3) press(10);
		press(75);
		ahb(0, BDM_REG_MASK, p);
		chk(32'({display_mode, fault}), 32'h6);
		port_state <= p[BDM_STATE_W-1:0] ^ 26'h1;
		ahb(0, BDM_REG_DIFF, 32'h1);
		chk(32'(fault), 32'h1);
		press(10);
		ahb(1, BDM_REG_CTRL, 32'h3);
		press(90);
		chk(32'(fr_cnt), 32'h0);
		ahb(0, BDM_REG_CTRL, 32'h3);
		press(160);
		chk(32'(fr_cnt), 32'h1);
		ahb(0, BDM_REG_CTRL, 32'h0);
		ahb(0, BDM_REG_MASK, 32'h0);
		end_of_test;
	end
endmodule : testbench
